// ===== design/pcs_return_stack.sv
// 31 x 21 return address storage, entries 1 to 31
`timescale 1ns/10ps
module pcs_return_stack
    import pcs_pkg::*;
(
    input wire logic mclk_in,
    pcs_stack_if.store stk
);

    // ----------------------------------------------------------------
    // storage; index zero has no entry and reads as zero
    // ----------------------------------------------------------------
    logic [20:0] mem_r [1:STK_DEPTH];

    always_ff @(posedge mclk_in) begin
        if (stk.wr_en && stk.wr_idx != SP_EMPTY) begin
            mem_r[stk.wr_idx] <= stk.wr_data;
        end
    end

    assign stk.rd_data = (stk.rd_idx == SP_EMPTY) ? '0 : mem_r[stk.rd_idx];

endmodule // pcs_return_stack

// ===== design/pcs_top.sv
// program counter, latches, config load and return stack control
//
// What this block does
// - 21-bit counter over 2 Mbyte; fetches beyond memory return zero.
// - Any reset loads 0000h; interrupts vector to 0008h and 0018h.
// - Reset copies the top four program words into config registers.
// - Config bytes ascend from word 1 low byte; word 4 is reserved.
// - Low byte is accessible; upper bits change only through latches.
// - Writing the low byte loads upper bits from both latches.
// - Reading the low byte copies upper bits into both latches.
// - Bit 0 stays zero; sequential fetch adds two.
// - Call and jump load targets directly, ignoring latches.
// - Calls and interrupts push; returns and unlink ops pop.
// - Calls and returns leave both latches unchanged.
// - Stack is 31 by 21 bits with 5-bit pointer, outside memory.
// - Push increments pointer first, then writes the current counter value.
// - Pop loads the addressed entry, then decrements pointer.
// - Pointer clears on reset; zero has no entry behind it.
// - Top-of-stack registers read and write the addressed entry.
// - Software reads and writes the pointer, 0 to 31.
// - Full flag sets after 31 pushes; only software or POR clear.
// - Fault reset enabled: 31st push stores PC+2, sets full, resets.
// - Fault reset off: pointer stops at 31, entry 31 kept.
// - Empty pop loads zero, sets underflow, pointer stays zero.
// - Push op stores current counter; pop op only decrements.
// - Pointer register: full bit 7, underflow 6, bit 5 zero.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module pcs_top
    import pcs_pkg::*;
#(
    parameter int PMEM_BYTES = PMEM_BYTES_DEF
) (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic dev_reset_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic op_valid_in,
    input wire logic [3:0] op_code_in,
    input wire logic [20:0] target_in,
    input wire logic [15:0] pmem_data_in,
    output logic [20:0] pmem_addr_out,
    output logic [15:0] fetch_data_out,
    output logic [20:0] pc_out,
    output logic busy_out,
    output logic dev_reset_req_out
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pcs_state_e state_r;
    logic [2:0] load_idx_r;
    logic [15:0] cfg_r [CFG_WORDS];
    logic [20:0] pc_r;
    logic [20:0] pc_nxt;
    logic [4:0] sp_r;
    logic [4:0] sp_nxt;
    logic [7:0] high_latch_r;
    logic [4:0] upper_latch_r;
    logic full_r;
    logic unf_r;
    logic pready_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [20:0] pmem_addr_r;
    logic [15:0] fetch_data_r;
    logic dev_reset_req_r;
    logic busy_r;
    logic any_reset;
    logic run_op;
    logic push;
    logic pop;
    logic full_set;
    logic unf_set;
    logic fault;
    logic fault_rst_en;
    logic ext_set_en;
    logic apb_wr;
    logic rd_take;
    logic [20:0] cfg_base;
    pcs_op_e op;

    pcs_stack_if stk();

    pcs_return_stack u_stack (
        .mclk_in(mclk_in),
        .stk(stk)
    );

    assign op = pcs_op_e'(op_code_in);
    assign any_reset = !resetn_in || dev_reset_in;
    // ops arriving while config words load are dropped; the core waits on busy
    assign run_op = op_valid_in && state_r == ST_RUN;
    assign apb_wr = psel_in && penable_in && pready_r && pwrite_in;
    // read side effects happen on the edge that captures read data
    assign rd_take = psel_in && penable_in && !pready_r && !pwrite_in;
    assign fault_rst_en = cfg_r[0][CFG_FAULT_RST_BIT];
    assign ext_set_en = cfg_r[0][CFG_EXT_SET_BIT];
    assign cfg_base = 21'(PMEM_BYTES - CFG_SPAN_BYTES);
    assign stk.rd_idx = sp_r;

    // ----------------------------------------------------------------
    // next counter and stack pointer
    // ----------------------------------------------------------------
    always_comb begin
        pc_nxt = pc_r;
        sp_nxt = sp_r;
        push = 1'b0;
        pop = 1'b0;
        full_set = 1'b0;
        unf_set = 1'b0;
        fault = 1'b0;
        stk.wr_en = 1'b0;
        stk.wr_idx = sp_r;
        stk.wr_data = pc_r;
        if (run_op) begin
            unique case (op)
                OP_STEP: pc_nxt = pcs_plus2(pc_r);
                OP_JUMP: pc_nxt = pcs_align(target_in);
                OP_CALL, OP_INT_HI, OP_INT_LO, OP_PUSH: push = 1'b1;
                OP_RET, OP_POP: pop = 1'b1;
                OP_UNLINK: pop = ext_set_en;
                // a 4-bit code can carry values outside the op set
                default: ;
            endcase
        end
        if (push) begin
            if (sp_r >= SP_LAST - SP_ONE) begin
                full_set = 1'b1;
                fault = fault_rst_en;
            end
            if (sp_r != SP_LAST) begin
                sp_nxt = sp_r + SP_ONE;
                stk.wr_en = 1'b1;
                stk.wr_idx = sp_r + SP_ONE;
            end
            if (fault) begin
                stk.wr_data = pcs_plus2(pc_r);
            end
            unique case (op)
                OP_CALL: pc_nxt = pcs_align(target_in);
                OP_INT_HI: pc_nxt = VEC_HI;
                OP_INT_LO: pc_nxt = VEC_LO;
                default: pc_nxt = pc_r;
            endcase
        end
        if (pop) begin
            if (sp_r == SP_EMPTY) begin
                unf_set = 1'b1;
            end else begin
                sp_nxt = sp_r - SP_ONE;
            end
            if (op != OP_POP) begin
                pc_nxt = stk.rd_data;
            end
        end
        if (fault) begin
            pc_nxt = RESET_VEC;
            sp_nxt = SP_EMPTY;
        end
        // counter and pointer writes yield to the core in the same cycle; top-of-stack writes yield only to a push
        if (apb_wr && !run_op && paddr_in == OFS_PC_LOW) begin
            pc_nxt = {upper_latch_r, high_latch_r,
                      pwdata_in[7:1], 1'b0};
        end
        if (apb_wr && !push && !pop && paddr_in == OFS_STACK_PTR) begin
            sp_nxt = pwdata_in[4:0];
        end
        if (apb_wr && !push && sp_r != SP_EMPTY) begin
            stk.wr_idx = sp_r;
            stk.wr_data = stk.rd_data;
            unique case (paddr_in)
                OFS_TOS_UPPER: begin
                    stk.wr_en = 1'b1;
                    stk.wr_data[20:16] = pwdata_in[4:0];
                end
                OFS_TOS_HIGH: begin
                    stk.wr_en = 1'b1;
                    stk.wr_data[15:8] = pwdata_in[7:0];
                end
                OFS_TOS_LOW: begin
                    stk.wr_en = 1'b1;
                    stk.wr_data[7:0] = pwdata_in[7:0];
                end
                default: stk.wr_data = pc_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // counter, pointer and fault reset request
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (any_reset) begin
            pc_r <= RESET_VEC;
            sp_r <= SP_EMPTY;
            dev_reset_req_r <= 1'b0;
        end else begin
            pc_r <= pcs_align(pc_nxt);
            sp_r <= sp_nxt;
            dev_reset_req_r <= fault;
        end
    end

    // ----------------------------------------------------------------
    // latches: software writes or low byte reads only
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (any_reset) begin
            high_latch_r <= LATCH_RESET;
            upper_latch_r <= LATCH_RESET[4:0];
        end else if (rd_take && paddr_in == OFS_PC_LOW) begin
            high_latch_r <= pc_r[15:8];
            upper_latch_r <= pc_r[20:16];
        end else if (apb_wr && paddr_in == OFS_HIGH_LATCH) begin
            high_latch_r <= pwdata_in[7:0];
        end else if (apb_wr && paddr_in == OFS_UPPER_LATCH) begin
            upper_latch_r <= pwdata_in[4:0];
        end
    end

    // ----------------------------------------------------------------
    // sticky flags: only power-on reset or software clear them
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            full_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            if (full_set) begin
                full_r <= 1'b1;
            end else if (apb_wr && paddr_in == OFS_STACK_PTR &&
                         !pwdata_in[SP_FULL_BIT]) begin
                full_r <= 1'b0;
            end
            if (unf_set) begin
                unf_r <= 1'b1;
            end else if (apb_wr && paddr_in == OFS_STACK_PTR &&
                         !pwdata_in[SP_UNF_BIT]) begin
                unf_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // config word load and fetch path
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (any_reset || fault) begin
            state_r <= ST_LOAD;
            busy_r <= 1'b1;
            load_idx_r <= 3'h0;
            pmem_addr_r <= cfg_base;
        end else if (state_r == ST_LOAD) begin
            load_idx_r <= load_idx_r + 3'h1;
            pmem_addr_r <= cfg_base + {17'h0, load_idx_r + 3'h1, 1'b0};
            if (load_idx_r == LOAD_LAST) begin
                state_r <= ST_RUN;
                busy_r <= 1'b0;
                pmem_addr_r <= pc_r;
            end
        end else begin
            pmem_addr_r <= pcs_align(pc_nxt);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                cfg_r[i] <= CFG_RESET;
            end
        end else if (state_r == ST_LOAD && load_idx_r != LOAD_LAST) begin
            // memory answers in the same cycle, so word n pairs with index n
            cfg_r[load_idx_r[1:0]] <= pmem_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (any_reset) begin
            fetch_data_r <= '0;
        end else if (32'(pmem_addr_r) < PMEM_BYTES) begin
            fetch_data_r <= pmem_data_in;
        end else begin
            fetch_data_r <= '0;
        end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait state, read data captured with pready
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            pready_r <= 1'b0;
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel_in && penable_in && !pready_r;
            if (psel_in && penable_in && !pready_r) begin
                pslverr_r <= 1'b0;
                prdata_r <= '0;
                unique case (paddr_in)
                    OFS_PC_LOW: prdata_r[7:0] <= pc_r[7:0];
                    OFS_HIGH_LATCH: prdata_r[7:0] <= high_latch_r;
                    OFS_UPPER_LATCH: prdata_r[4:0] <= upper_latch_r;
                    OFS_STACK_PTR: prdata_r[7:0] <= {full_r, unf_r,
                                                     1'b0, sp_r};
                    OFS_TOS_UPPER: prdata_r[4:0] <= stk.rd_data[20:16];
                    OFS_TOS_HIGH: prdata_r[7:0] <= stk.rd_data[15:8];
                    OFS_TOS_LOW: prdata_r[7:0] <= stk.rd_data[7:0];
                    OFS_CFG_12: prdata_r <= {cfg_r[1], cfg_r[0]};
                    OFS_CFG_34: prdata_r <= {cfg_r[3], cfg_r[2]};
                    OFS_STATUS: prdata_r[0] <= state_r == ST_LOAD;
                    default: pslverr_r <= 1'b1;
                endcase
            end else if (!psel_in) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata_out = prdata_r;
    assign pready_out = pready_r;
    assign pslverr_out = pslverr_r;
    assign pmem_addr_out = pmem_addr_r;
    assign fetch_data_out = fetch_data_r;
    assign pc_out = pc_r;
    assign busy_out = busy_r;
    assign dev_reset_req_out = dev_reset_req_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    a_pc_aligned: assert property (
        pc_r[0] == 1'b0 && pmem_addr_r[0] == 1'b0)
        else $error("counter lost word alignment");

    a_step_by_two: assert property (
        run_op && op == OP_STEP && !dev_reset_in && !apb_wr
        |=> pc_r == $past(pc_r) + PC_STEP)
        else $error("sequential fetch did not add two");

    a_reset_vector: assert property (
        dev_reset_in |=> pc_r == RESET_VEC && sp_r == SP_EMPTY && busy_out)
        else $error("reset did not clear counter and pointer");

    a_int_vector: assert property (
        run_op && op == OP_INT_HI && sp_r < SP_LAST - SP_ONE && !dev_reset_in
        |=> pc_r == VEC_HI && sp_r == $past(sp_r) + SP_ONE)
        else $error("high interrupt vector wrong");

    a_push_pop_pair: assert property (
        run_op && op == OP_CALL && sp_r < SP_LAST - SP_ONE && !dev_reset_in
        ##1 run_op && op == OP_RET && !dev_reset_in
        |=> pc_r == $past(pc_r, 2) && sp_r == $past(sp_r, 2))
        else $error("return did not restore pushed address");

    a_underflow: assert property (
        run_op && op == OP_RET && sp_r == SP_EMPTY && !dev_reset_in
        |=> pc_r == RESET_VEC && unf_r && sp_r == SP_EMPTY && !busy_out)
        else $error("empty pop handled wrongly");

    a_full_stop: assert property (
        run_op && op == OP_CALL && sp_r == SP_LAST && !fault_rst_en &&
        !dev_reset_in |=> sp_r == SP_LAST && full_r && !dev_reset_req_out)
        else $error("pointer moved past the last entry");

    a_fault_reset: assert property (
        push && sp_r == SP_LAST - SP_ONE && fault_rst_en && !dev_reset_in
        |=> dev_reset_req_out && full_r && sp_r == SP_EMPTY
        ##1 !dev_reset_req_out && full_r)
        else $error("stack fault reset sequence wrong");

    a_latch_keep: assert property (
        (push || pop) && !apb_wr && !rd_take && !dev_reset_in
        |=> $stable(high_latch_r) && $stable(upper_latch_r))
        else $error("call or return touched a latch");

    a_sp_priority: assert property (
        apb_wr && paddr_in == OFS_STACK_PTR && push && sp_r < 5'h1e &&
        !dev_reset_in |=> sp_r == $past(sp_r) + SP_ONE)
        else $error("software pointer write beat a push");

endmodule // pcs_top

// ===== inc/pcs_pkg.sv
// constants and types shared by the program counter and return stack
package pcs_pkg;

    // ----------------------------------------------------------------
    // widths and sizes
    // ----------------------------------------------------------------
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int STK_DEPTH = 31;
    localparam int CFG_WORDS = 4;
    localparam int CFG_SPAN_BYTES = 8;
    localparam int PMEM_BYTES_DEF = 131072;

    // ----------------------------------------------------------------
    // vectors and counter values
    // ----------------------------------------------------------------
    localparam logic [20:0] RESET_VEC = 21'h000000;
    localparam logic [20:0] VEC_HI = 21'h000008;
    localparam logic [20:0] VEC_LO = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [4:0] SP_EMPTY = 5'h00;
    localparam logic [4:0] SP_LAST = 5'h1f;
    localparam logic [4:0] SP_ONE = 5'h01;
    localparam logic [15:0] CFG_RESET = 16'hffff;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [2:0] LOAD_LAST = 3'h4;

    // ----------------------------------------------------------------
    // register offsets and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PC_LOW = 8'h00;
    localparam logic [7:0] OFS_HIGH_LATCH = 8'h04;
    localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [7:0] OFS_STACK_PTR = 8'h0c;
    localparam logic [7:0] OFS_TOS_UPPER = 8'h10;
    localparam logic [7:0] OFS_TOS_HIGH = 8'h14;
    localparam logic [7:0] OFS_TOS_LOW = 8'h18;
    localparam logic [7:0] OFS_CFG_12 = 8'h1c;
    localparam logic [7:0] OFS_CFG_34 = 8'h20;
    localparam logic [7:0] OFS_STATUS = 8'h24;
    localparam int SP_FULL_BIT = 7;
    localparam int SP_UNF_BIT = 6;
    localparam int CFG_FAULT_RST_BIT = 5;
    localparam int CFG_EXT_SET_BIT = 6;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_STEP, OP_JUMP, OP_CALL, OP_INT_HI, OP_INT_LO,
        OP_RET, OP_UNLINK, OP_PUSH, OP_POP
    } pcs_op_e;

    typedef enum logic {ST_LOAD, ST_RUN} pcs_state_e;

    function automatic logic [20:0] pcs_plus2(input logic [20:0] pc);
        return pc + PC_STEP;
    endfunction

    function automatic logic [20:0] pcs_align(input logic [20:0] a);
        return {a[20:1], 1'b0};
    endfunction

endpackage

// ===== inc/pcs_stack_if.sv
// port bundle between the sequencer and the return stack storage
`timescale 1ns/10ps
interface pcs_stack_if;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [20:0] wr_data;
    logic [4:0] rd_idx;
    logic [20:0] rd_data;
    modport owner(output wr_en, output wr_idx, output wr_data,
                  output rd_idx, input rd_data);
    modport store(input wr_en, input wr_idx, input wr_data,
                  input rd_idx, output rd_data);
endinterface

// ===== test/pcs_pmem_model.sv
// program memory model: code pattern plus the four config words on top
`timescale 1ns/10ps
module pcs_pmem_model
    import pcs_pkg::*;
#(
    parameter int PMEM_BYTES = 65536,
    parameter logic [15:0] CFG2 = 16'h1234,
    parameter logic [15:0] CFG3 = 16'h5678,
    parameter logic [15:0] CFG4 = 16'h9abc
) (
    input wire logic [20:0] addr_in,
    input wire logic [15:0] cfg1_in,
    output logic [15:0] data_out
);
    localparam logic [20:0] BASE = 21'(PMEM_BYTES - CFG_SPAN_BYTES);
    // --------------------------------------------------------------
    // read path
    // --------------------------------------------------------------
    // the array keeps answering past its end; zeroing is not ours
    always_comb begin
        case (addr_in)
            BASE: data_out = cfg1_in;
            BASE + 21'h2: data_out = CFG2;
            BASE + 21'h4: data_out = CFG3;
            BASE + 21'h6: data_out = CFG4;
            default: data_out = addr_in[16:1] ^ 16'h3c00;
        endcase
    end
endmodule // pcs_pmem_model

// ===== test/pcs_top_tb.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/10ps
module pcs_top_tb;
    import pcs_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic dev_reset_in = 1'b0;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, er, busy_out, dev_reset_req_out;
    logic op_valid_in = 1'b0;
    logic [3:0] op_code_in = 4'h0;
    logic [20:0] target_in = 21'h0, pmem_addr_out, pc_out;
    logic [15:0] pmem_data_in, fetch_data_out;
    logic [15:0] cfg1 = 16'h0000;
    int num_errors = 0, n_checks = 0, n_rst = 0, cyc = 0;

    pcs_top #(.PMEM_BYTES(65536)) dut (.mclk_in(mclk_in),
        .resetn_in(resetn_in), .dev_reset_in(dev_reset_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .op_valid_in(op_valid_in),
        .op_code_in(op_code_in), .target_in(target_in),
        .pmem_data_in(pmem_data_in), .pmem_addr_out(pmem_addr_out),
        .fetch_data_out(fetch_data_out), .pc_out(pc_out),
        .busy_out(busy_out), .dev_reset_req_out(dev_reset_req_out));
    pcs_pmem_model #(.PMEM_BYTES(65536)) mem (.addr_in(pmem_addr_out),
        .cfg1_in(cfg1), .data_out(pmem_data_in));

    // ------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc++;
        if (dev_reset_req_out === 1'b1) n_rst++;
        if (cyc == 20000) begin
            num_errors++;
            test_done;
        end
    end
    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge mclk_in);
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        #1;
    endtask
    task automatic op(input pcs_op_e c, input logic [20:0] t);
        @(posedge mclk_in);
        op_valid_in <= 1'b1;
        op_code_in <= c;
        target_in <= t;
        @(posedge mclk_in);
        op_valid_in <= 1'b0;
        #1;
    endtask
    // two ops on consecutive edges
    task automatic op2(input pcs_op_e c1, input pcs_op_e c2,
                       input logic [20:0] t);
        @(posedge mclk_in);
        op_valid_in <= 1'b1;
        op_code_in <= c1;
        target_in <= t;
        @(posedge mclk_in);
        op_code_in <= c2;
        @(posedge mclk_in);
        op_valid_in <= 1'b0;
        #1;
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (busy_out !== 1'b0 && n < 40);
        #1;
        chk(32'(busy_out), 32'h0);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk(32'(pc_out), 32'h0);
        rchk(OFS_STACK_PTR, 32'h0);
        rchk(OFS_CFG_12, {16'h1234, cfg1});
        rchk(OFS_CFG_34, 32'h9abc5678);
        rchk(OFS_STATUS, 32'h0);
        rchk(8'h40, 32'h0);
        chk(32'(er), 32'h1);
    endtask
    task automatic t_fetch;
        op(OP_STEP, 21'h0);
        op(OP_STEP, 21'h0);
        chk(32'(pc_out), 32'h4);
        chk(32'(pmem_addr_out), 32'h4);
        repeat (3) @(posedge mclk_in);
        chk(32'(fetch_data_out), 32'h3c02);
        op(OP_JUMP, 21'h1f0001);
        chk(32'(pc_out), 32'h1f0000);
        repeat (3) @(posedge mclk_in);
        chk(32'(fetch_data_out), 32'h0);
    endtask
    task automatic t_latch;
        apb(1'b1, OFS_HIGH_LATCH, 32'h12);
        apb(1'b1, OFS_UPPER_LATCH, 32'h0a);
        chk(32'(pc_out), 32'h1f0000);
        apb(1'b1, OFS_PC_LOW, 32'h35);
        chk(32'(pc_out), 32'h0a1234);
        op(OP_JUMP, 21'h054321);
        chk(32'(pc_out), 32'h054320);
        op(OP_CALL, 21'h1b0156);
        rchk(OFS_HIGH_LATCH, 32'h12);
        rchk(OFS_PC_LOW, 32'h56);
        rchk(OFS_HIGH_LATCH, 32'h01);
        rchk(OFS_UPPER_LATCH, 32'h1b);
    endtask
    task automatic t_stack;
        rchk(OFS_STACK_PTR, 32'h1);
        rchk(OFS_TOS_UPPER, 32'h05);
        rchk(OFS_TOS_HIGH, 32'h43);
        rchk(OFS_TOS_LOW, 32'h20);
        op(OP_INT_HI, 21'h0);
        chk(32'(pc_out), 32'h8);
        op(OP_INT_LO, 21'h0);
        chk(32'(pc_out), 32'h18);
        op(OP_UNLINK, 21'h0);
        rchk(OFS_STACK_PTR, 32'h3);
        op(OP_RET, 21'h0);
        chk(32'(pc_out), 32'h8);
        apb(1'b1, OFS_TOS_LOW, 32'h60);
        op(OP_RET, 21'h0);
        chk(32'(pc_out), 32'h1b0160);
        rchk(OFS_STACK_PTR, 32'h1);
        apb(1'b1, OFS_STACK_PTR, 32'h1f);
        rchk(OFS_STACK_PTR, 32'h1f);
        apb(1'b1, OFS_STACK_PTR, 32'h0);
    endtask
    // call then return on back-to-back edges; push against a pointer write
    task automatic t_race;
        op2(OP_CALL, OP_RET, 21'h000a00);
        chk(32'(pc_out), 32'h1b0160);
        fork
            apb(1'b1, OFS_STACK_PTR, 32'h1f);
            begin
                repeat (2) @(posedge mclk_in);
                op(OP_PUSH, 21'h0);
            end
        join
        rchk(OFS_STACK_PTR, 32'h1);
        op(OP_POP, 21'h0);
        rchk(OFS_STACK_PTR, 32'h0);
    endtask
    task automatic t_unf;
        op(OP_PUSH, 21'h0);
        chk(32'(pc_out), 32'h1b0160);
        rchk(OFS_TOS_LOW, 32'h60);
        op(OP_POP, 21'h0);
        chk(32'(pc_out), 32'h1b0160);
        op(OP_RET, 21'h0);
        chk(32'(pc_out), 32'h0);
        rchk(OFS_STACK_PTR, 32'h40);
        apb(1'b1, OFS_STACK_PTR, 32'h0);
        rchk(OFS_STACK_PTR, 32'h0);
    endtask
    task automatic t_full;
        for (int i = 0; i < 31; i++) op(OP_CALL, 21'h000200);
        rchk(OFS_STACK_PTR, 32'h9f);
        op(OP_CALL, 21'h000300);
        rchk(OFS_STACK_PTR, 32'h9f);
        rchk(OFS_TOS_HIGH, 32'h02);
        cfg1 <= 16'h0060;
        @(posedge mclk_in);
        dev_reset_in <= 1'b1;
        @(posedge mclk_in);
        dev_reset_in <= 1'b0;
        wait_idle;
        rchk(OFS_STACK_PTR, 32'h80);
        rchk(OFS_CFG_12, 32'h12340060);
        apb(1'b1, OFS_STACK_PTR, 32'h0);
        rchk(OFS_STACK_PTR, 32'h0);
    endtask
    // fault reset enabled and the extended set on from here
    task automatic t_fault;
        op(OP_JUMP, 21'h000700);
        op(OP_CALL, 21'h000400);
        op(OP_UNLINK, 21'h0);
        chk(32'(pc_out), 32'h700);
        apb(1'b1, OFS_STACK_PTR, 32'h1e);
        op(OP_JUMP, 21'h000500);
        op(OP_CALL, 21'h000600);
        wait_idle;
        chk(32'(n_rst), 32'h1);
        chk(32'(pc_out), 32'h0);
        rchk(OFS_STACK_PTR, 32'h80);
        apb(1'b1, OFS_STACK_PTR, 32'h9f);
        rchk(OFS_TOS_LOW, 32'h02);
    endtask

    initial begin
        repeat (5) @(posedge mclk_in);
        resetn_in <= 1'b1;
        wait_idle;
        t_reset;
        t_fetch;
        t_latch;
        t_stack;
        t_race;
        t_unf;
        t_full;
        t_fault;
        test_done;
    end
endmodule // pcs_top_tb
